// file: design/crf_pkg.sv
// package for the core register file: special function addresses,
// reset values, status word layout and the request structs.
// assumes one processor clock; all requests come from logic on that clock.
`default_nettype none

package crf_pkg;

  // ==========================================================================
  // special function addresses (direct addressing only)
  localparam logic [7:0] SFR_BASE = 8'h80;
  localparam logic [7:0] ADDR_SP = 8'h81;
  localparam logic [7:0] ADDR_DPL = 8'h82;
  localparam logic [7:0] ADDR_DPH = 8'h83;
  localparam logic [7:0] ADDR_SECONDARY_POINTER_CONTROL = 8'h85;
  localparam logic [7:0] ADDR_POINTER_MODE_SELECT = 8'h86;
  localparam logic [7:0] ADDR_PSW = 8'hD0;
  localparam logic [7:0] ADDR_ACC = 8'hE0;
  localparam logic [7:0] ADDR_B = 8'hF0;

  // ==========================================================================
  // working register banks
  localparam logic [7:0] WREG_TOP = 8'h20;
  localparam int WREG_COUNT = 32;

  // ==========================================================================
  // reset values
  localparam logic [7:0] SP_RESET = 8'h07;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] DATA_POINTER_RESET = 16'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // ==========================================================================
  // status word bit positions
  localparam int PSW_CY = 7;
  localparam int PSW_AC = 6;
  localparam int PSW_F0 = 5;
  localparam int PSW_RS1 = 4;
  localparam int PSW_RS0 = 3;
  localparam int PSW_OV = 2;
  localparam int PSW_P = 0;

  // ==========================================================================
  // pointer control fields
  localparam int SECONDARY_POINTER_CONTROL_AT = 6;
  localparam logic [7:0] SECONDARY_POINTER_CONTROL_MASK = 8'h47;
  localparam logic [7:0] POINTER_MODE_SELECT_MASK = 8'h0F;
  localparam logic [1:0] MODE_INC = 2'h1;
  localparam logic [1:0] MODE_DEC = 2'h2;

  // ==========================================================================
  // request carriers
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } crf_mem_req_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic value;
  } crf_bit_req_t;

  typedef struct packed {
    logic acc_we;
    logic [7:0] acc;
    logic b_we;
    logic [7:0] b;
    logic cy_we;
    logic cy;
    logic ac_we;
    logic ac;
    logic ov_we;
    logic ov;
    logic clr_ov;
  } crf_alu_upd_t;

endpackage

`default_nettype wire

// file: design/crf_wreg_ram.sv
// storage for the four banks of eight working registers, in flip-flops.
// port a (bank/number access) wins over port b (memory access) on the
// same entry in the same cycle.
`default_nettype none

module crf_wreg_ram (
  input wire logic clk, // processor clock
  input wire logic rst_b, // synchronised reset, active low
  input wire logic a_we, // port a write
  input wire logic [4:0] a_idx, // port a entry
  input wire logic [7:0] a_wdata, // port a write data
  output logic [7:0] a_rdata, // port a read data
  input wire logic b_we, // port b write
  input wire logic [4:0] b_idx, // port b entry
  input wire logic [7:0] b_wdata, // port b write data
  output logic [7:0] b_rdata // port b read data
);

  logic [7:0] mem_q [crf_pkg::WREG_COUNT];

  // ==========================================================================
  // one flip-flop byte per entry
  for (genvar i = 0; i < crf_pkg::WREG_COUNT; i++) begin : g_ent
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        mem_q[i] <= crf_pkg::BYTE_RESET;
      end else if (a_we && a_idx == 5'(i)) begin
        mem_q[i] <= a_wdata;
      end else if (b_we && b_idx == 5'(i)) begin
        mem_q[i] <= b_wdata;
      end
    end
  end

  assign a_rdata = mem_q[a_idx];
  assign b_rdata = mem_q[b_idx];

endmodule

`default_nettype wire

// file: design/crf_core_regs.sv
// core register set: data pointers, instruction pointer, operand and
// helper registers, stack pointer, status word and working register banks.
// assumes the execution unit drives all requests on clk and keeps push and
// pop apart in time.
`default_nettype none

module crf_core_regs (
  input wire logic clk, // processor clock, 50 MHz
  input wire logic rst_b, // asynchronous reset, active low
  input wire crf_pkg::crf_mem_req_t dir_req, // direct byte access
  output logic [7:0] dir_rdata, // direct read data, one cycle later
  output logic dir_hit, // direct access reached this block
  input wire crf_pkg::crf_mem_req_t ind_req, // indirect byte access
  output logic [7:0] ind_rdata, // indirect read data, one cycle later
  output logic ind_hit, // indirect access reached the banks
  input wire crf_pkg::crf_bit_req_t bit_req, // bit access
  output logic bit_rdata, // bit read data, one cycle later
  output logic bit_hit, // bit access reached this block
  input wire crf_pkg::crf_alu_upd_t alu_upd, // result and flag updates
  input wire logic [2:0] rn_sel, // working register number
  input wire logic rn_we, // working register write
  input wire logic [7:0] rn_wdata, // working register write data
  output logic [7:0] rn_rdata, // working register read data
  input wire logic pc_load, // load instruction pointer
  input wire logic [15:0] pc_value, // value to load
  input wire logic pc_inc, // step instruction pointer
  output logic [15:0] pc, // instruction pointer
  input wire logic sp_push, // push: pointer steps up first
  input wire logic sp_pop, // pop: pointer steps down after
  output logic [7:0] stack_addr, // byte address for this push or pop
  input wire logic data_pointer_use, // active pointer used for an access
  output logic [15:0] data_pointer, // active data pointer
  output logic [7:0] acc, // main operand register
  output logic [7:0] b_reg, // helper register
  output logic [15:0] muldiv_pair, // helper:operand pair for mul/div
  output logic [7:0] status_word_flags // status word with live parity
);

  // ==========================================================================
  // reset release
  logic rst_meta_q, rst_sync_b;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_q <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_b <= rst_meta_q;
    end
  end

  // ==========================================================================
  // architectural state
  logic [15:0] pc_q, dp_q [2];
  logic [7:0] acc_q, acc_d, b_q, b_d, psw_q, psw_d, sp_q, sp_d, secondary_pointer_control_q, pointer_mode_select_q;
  logic act;
  logic parity;
  logic [7:0] psw_rd;

  assign act = secondary_pointer_control_q[0];
  assign parity = ^acc_q;
  // bit 0 is never stored: it always reflects the operand register
  assign psw_rd = {psw_q[7:1], parity};

  // ==========================================================================
  // special register read decode
  function automatic logic [8:0] sfr_read(input logic [7:0] a);
    logic [8:0] r;
    r = {1'b1, 8'h00};
    unique case (a)
      crf_pkg::ADDR_SP: r[7:0] = sp_q;
      crf_pkg::ADDR_DPL: r[7:0] = dp_q[act][7:0];
      crf_pkg::ADDR_DPH: r[7:0] = dp_q[act][15:8];
      crf_pkg::ADDR_SECONDARY_POINTER_CONTROL: r[7:0] = secondary_pointer_control_q;
      crf_pkg::ADDR_POINTER_MODE_SELECT: r[7:0] = pointer_mode_select_q;
      crf_pkg::ADDR_PSW: r[7:0] = psw_rd;
      crf_pkg::ADDR_ACC: r[7:0] = acc_q;
      crf_pkg::ADDR_B: r[7:0] = b_q;
      default: r = 9'h000; // unoccupied: not ours, reads as zero
    endcase
    return r;
  endfunction

  // ==========================================================================
  // access decode
  wire dir_sfr = dir_req.valid && dir_req.addr[7];
  wire dir_ram = dir_req.valid && dir_req.addr < crf_pkg::WREG_TOP;
  logic [8:0] dir_sfr_rd, bit_sfr_rd;
  // indirect never reaches the special space, and yields to a direct bank access
  wire ind_ram = ind_req.valid && ind_req.addr < crf_pkg::WREG_TOP && !dir_ram;
  wire [7:0] bit_byte = {bit_req.addr[7:3], 3'b000};
  wire bit_bank = bit_byte == crf_pkg::ADDR_PSW || bit_byte == crf_pkg::ADDR_ACC ||
                  bit_byte == crf_pkg::ADDR_B;
  wire bit_ok = bit_req.valid && bit_req.addr[7] && bit_bank;
  always_comb begin // a process, so register state read inside the function wakes it
    dir_sfr_rd = sfr_read(dir_req.addr);
    bit_sfr_rd = sfr_read(bit_byte);
  end
  wire [7:0] bit_cur = bit_sfr_rd[7:0];
  wire [7:0] bit_mask = 8'h01 << bit_req.addr[2:0];
  wire [7:0] bit_new = bit_req.value ? (bit_cur | bit_mask) : (bit_cur & ~bit_mask);
  // one special write per cycle: a byte write beats a bit write
  wire dir_sfr_we = dir_sfr && dir_req.write && dir_sfr_rd[8];
  wire sfr_we = dir_sfr_we || (bit_ok && bit_req.write);
  wire [7:0] sfr_wa = dir_sfr_we ? dir_req.addr : bit_byte;
  wire [7:0] sfr_wd = dir_sfr_we ? dir_req.wdata : bit_new;
  wire we_sp = sfr_we && sfr_wa == crf_pkg::ADDR_SP;
  wire we_dpl = sfr_we && sfr_wa == crf_pkg::ADDR_DPL;
  wire we_dph = sfr_we && sfr_wa == crf_pkg::ADDR_DPH;
  wire we_secondary_pointer_control = sfr_we && sfr_wa == crf_pkg::ADDR_SECONDARY_POINTER_CONTROL;
  wire we_pointer_mode_select = sfr_we && sfr_wa == crf_pkg::ADDR_POINTER_MODE_SELECT;
  wire we_psw = sfr_we && sfr_wa == crf_pkg::ADDR_PSW;
  wire we_acc = sfr_we && sfr_wa == crf_pkg::ADDR_ACC;
  wire we_b = sfr_we && sfr_wa == crf_pkg::ADDR_B;

  // ==========================================================================
  // working register banks
  wire [1:0] bank = {psw_q[crf_pkg::PSW_RS1], psw_q[crf_pkg::PSW_RS0]};
  wire [4:0] rn_idx = {bank, rn_sel};
  wire [4:0] mem_idx = dir_ram ? dir_req.addr[4:0] : ind_req.addr[4:0];
  wire mem_we = (dir_ram && dir_req.write) || (ind_ram && ind_req.write);
  wire [7:0] mem_wd = dir_ram ? dir_req.wdata : ind_req.wdata;
  logic [7:0] mem_rd;

  crf_wreg_ram u_wreg (
    .clk(clk),
    .rst_b(rst_sync_b),
    .a_we(rn_we),
    .a_idx(rn_idx),
    .a_wdata(rn_wdata),
    .a_rdata(rn_rdata),
    .b_we(mem_we),
    .b_idx(mem_idx),
    .b_wdata(mem_wd),
    .b_rdata(mem_rd)
  );

  // ==========================================================================
  // status word, operand and helper next values
  always_comb begin
    psw_d = psw_q;
    if (we_psw) psw_d = sfr_wd & ~(8'h01 << crf_pkg::PSW_P); // user flag only here
    if (alu_upd.clr_ov) psw_d[crf_pkg::PSW_OV] = 1'b0;
    if (alu_upd.ov_we) psw_d[crf_pkg::PSW_OV] = alu_upd.ov;
    if (alu_upd.cy_we) psw_d[crf_pkg::PSW_CY] = alu_upd.cy;
    if (alu_upd.ac_we) psw_d[crf_pkg::PSW_AC] = alu_upd.ac;
  end

  assign acc_d = alu_upd.acc_we ? alu_upd.acc : (we_acc ? sfr_wd : acc_q);
  assign b_d = alu_upd.b_we ? alu_upd.b : (we_b ? sfr_wd : b_q);
  assign sp_d = sp_push ? sp_q + 8'h01 : (sp_pop ? sp_q - 8'h01 : (we_sp ? sfr_wd : sp_q));

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      psw_q <= crf_pkg::BYTE_RESET; // bank zero active
      acc_q <= crf_pkg::BYTE_RESET;
      b_q <= crf_pkg::BYTE_RESET;
      sp_q <= crf_pkg::SP_RESET;
    end else begin
      psw_q <= psw_d;
      acc_q <= acc_d;
      b_q <= b_d;
      sp_q <= sp_d;
    end
  end

  // ==========================================================================
  // instruction pointer and pointer control
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      pc_q <= crf_pkg::PC_RESET;
      secondary_pointer_control_q <= crf_pkg::BYTE_RESET;
      pointer_mode_select_q <= crf_pkg::BYTE_RESET;
    end else begin
      pc_q <= pc_load ? pc_value : (pc_inc ? pc_q + 16'h0001 : pc_q);
      if (we_secondary_pointer_control) begin
        secondary_pointer_control_q <= sfr_wd & crf_pkg::SECONDARY_POINTER_CONTROL_MASK;
      end else if (data_pointer_use && secondary_pointer_control_q[crf_pkg::SECONDARY_POINTER_CONTROL_AT]) begin
        secondary_pointer_control_q[0] <= ~secondary_pointer_control_q[0]; // auto toggle swaps source and target
      end
      if (we_pointer_mode_select) begin
        pointer_mode_select_q <= sfr_wd & crf_pkg::POINTER_MODE_SELECT_MASK;
      end
    end
  end

  // ==========================================================================
  // two data pointers; software byte writes win over an automatic step
  for (genvar g = 0; g < 2; g++) begin : g_dp
    wire sel = act == 1'(g);
    wire [1:0] mode = pointer_mode_select_q[2*g +: 2];
    wire [15:0] step = mode == crf_pkg::MODE_INC ? dp_q[g] + 16'h0001 :
                       mode == crf_pkg::MODE_DEC ? dp_q[g] - 16'h0001 : dp_q[g];
    always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
        dp_q[g] <= crf_pkg::DATA_POINTER_RESET;
      end else if (sel && (we_dpl || we_dph)) begin
        if (we_dpl) begin
          dp_q[g][7:0] <= sfr_wd;
        end
        if (we_dph) begin
          dp_q[g][15:8] <= sfr_wd;
        end
      end else if (sel && data_pointer_use) begin
        dp_q[g] <= step;
      end
    end
  end

  // ==========================================================================
  // registered answers
  logic [7:0] dir_rdata_q, ind_rdata_q;
  logic dir_hit_q, ind_hit_q, bit_rdata_q, bit_hit_q;
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      dir_rdata_q <= crf_pkg::BYTE_RESET;
      ind_rdata_q <= crf_pkg::BYTE_RESET;
      dir_hit_q <= 1'b0;
      ind_hit_q <= 1'b0;
      bit_rdata_q <= 1'b0;
      bit_hit_q <= 1'b0;
    end else begin
      dir_rdata_q <= dir_ram ? mem_rd : dir_sfr_rd[7:0];
      dir_hit_q <= dir_ram || (dir_sfr && dir_sfr_rd[8]);
      ind_rdata_q <= ind_ram ? mem_rd : crf_pkg::BYTE_RESET;
      ind_hit_q <= ind_ram;
      bit_rdata_q <= bit_ok && bit_cur[bit_req.addr[2:0]];
      bit_hit_q <= bit_ok;
    end
  end

  assign dir_rdata = dir_rdata_q;
  assign dir_hit = dir_hit_q;
  assign ind_rdata = ind_rdata_q;
  assign ind_hit = ind_hit_q;
  assign bit_rdata = bit_rdata_q;
  assign bit_hit = bit_hit_q;
  assign pc = pc_q;
  assign stack_addr = sp_push ? sp_q + 8'h01 : sp_q;
  assign data_pointer = dp_q[act]; // base for jumps, lookups, external data
  assign acc = acc_q;
  assign b_reg = b_q;
  assign muldiv_pair = {b_q, acc_q};
  assign status_word_flags = psw_rd;

  // ==========================================================================
  // checks
  logic pc_moved_q, sp_moved_q;
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      pc_moved_q <= 1'b0;
      sp_moved_q <= 1'b0;
    end else begin
      pc_moved_q <= pc_moved_q || pc_load || pc_inc;
      sp_moved_q <= sp_moved_q || sp_push || sp_pop || we_sp;
    end
  end

  property p_dpl_write;
    @(posedge clk) disable iff (!rst_sync_b)
    (we_dpl && !we_dph) |=> data_pointer[7:0] == $past(sfr_wd) || act != $past(act);
  endproperty
  a_dpl_write: assert property (p_dpl_write) else $error("low pointer byte not written");
  property p_pc_reset;
    @(posedge clk) disable iff (!rst_sync_b)
    !pc_moved_q |-> pc == 16'h0000;
  endproperty
  a_pc_reset: assert property (p_pc_reset) else $error("pointer left zero unasked");
  property p_acc_result;
    @(posedge clk) disable iff (!rst_sync_b)
    alu_upd.acc_we |=> acc == $past(alu_upd.acc) && muldiv_pair[7:0] == acc;
  endproperty
  a_acc_result: assert property (p_acc_result) else $error("operand result lost");
  property p_bank_map;
    @(posedge clk) disable iff (!rst_sync_b)
    (rn_we ##1 (rn_sel == $past(rn_sel) && bank == $past(bank))) |-> rn_rdata == $past(rn_wdata);
  endproperty
  a_bank_map: assert property (p_bank_map) else $error("working register write lost");
  property p_sp_reset;
    @(posedge clk) disable iff (!rst_sync_b)
    !sp_moved_q |-> sp_q == 8'h07 && stack_addr <= 8'h08;
  endproperty
  a_sp_reset: assert property (p_sp_reset) else $error("stack pointer reset wrong");
  property p_carry;
    @(posedge clk) disable iff (!rst_sync_b)
    alu_upd.cy_we |=> status_word_flags[7] == $past(alu_upd.cy);
  endproperty
  a_carry: assert property (p_carry) else $error("carry flag not updated");
  property p_user_flag;
    @(posedge clk) disable iff (!rst_sync_b)
    !we_psw |=> $stable(status_word_flags[5]);
  endproperty
  a_user_flag: assert property (p_user_flag) else $error("user flag moved by hardware");
  property p_wrap;
    @(posedge clk) disable iff (!rst_sync_b)
    (alu_upd.clr_ov && !alu_upd.ov_we) |=> !status_word_flags[2];
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap flag not cleared");
  property p_parity;
    @(posedge clk) disable iff (!rst_sync_b)
    alu_upd.acc_we |=> status_word_flags[0] == ^$past(alu_upd.acc);
  endproperty
  a_parity: assert property (p_parity) else $error("parity does not track operand");
  property p_indirect;
    @(posedge clk) disable iff (!rst_sync_b)
    (ind_req.valid && ind_req.addr[7]) |=> !ind_hit && ind_rdata == 8'h00;
  endproperty
  a_indirect: assert property (p_indirect) else $error("indirect reached special space");
  property p_push;
    @(posedge clk) disable iff (!rst_sync_b)
    sp_push |-> stack_addr == sp_q + 8'h01 ##1 sp_q == $past(stack_addr);
  endproperty
  a_push: assert property (p_push) else $error("push did not pre-increment");

endmodule

`default_nettype wire

// file: test/testbench.sv
// self-checking bench for the core register set: direct, indirect and bit
// access, bank mapping, flags, stack, pointers and reset.
// assumes crf_pkg is compiled first and that the design keeps its own assertions.
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================================
  // stimulus and observation
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic hit;
    logic rd;
    logic [7:0] rdata;
  } crf_row_t;

  logic clk = 1'h0;
  logic rst_b = 1'h0;
  crf_pkg::crf_mem_req_t dir_req, ind_req;
  crf_pkg::crf_bit_req_t bit_req;
  crf_pkg::crf_alu_upd_t alu_upd;
  logic [2:0] rn_sel;
  logic rn_we, pc_load, pc_inc, sp_push, sp_pop, data_pointer_use, bit_rdata, bit_hit;
  logic dir_hit, ind_hit;
  logic [7:0] rn_wdata, dir_rdata, ind_rdata, rn_rdata, stack_addr, acc, b_reg, status_word_flags;
  logic [15:0] pc_value, pc, data_pointer, muldiv_pair;
  int failures = 0;
  int check_count = 0;

  // ordinary direct accesses: write, hit, check read data, expected read data
  crf_row_t rows [16] = '{
    '{1'h1, 8'hE0, 8'h96, 1'h1, 1'h0, 8'h00}, '{1'h0, 8'hE0, 8'h00, 1'h1, 1'h1, 8'h96},
    '{1'h1, 8'hF0, 8'h5A, 1'h1, 1'h0, 8'h00}, '{1'h0, 8'hF0, 8'h00, 1'h1, 1'h1, 8'h5A},
    '{1'h1, 8'h82, 8'h34, 1'h1, 1'h0, 8'h00}, '{1'h1, 8'h83, 8'h12, 1'h1, 1'h0, 8'h00},
    '{1'h0, 8'h82, 8'h00, 1'h1, 1'h1, 8'h34}, '{1'h0, 8'h83, 8'h00, 1'h1, 1'h1, 8'h12},
    '{1'h0, 8'h81, 8'h00, 1'h1, 1'h1, 8'h07}, '{1'h1, 8'hD0, 8'hA9, 1'h1, 1'h0, 8'h00},
    '{1'h0, 8'hD0, 8'h00, 1'h1, 1'h1, 8'hA8}, '{1'h1, 8'h84, 8'hFF, 1'h0, 1'h0, 8'h00},
    '{1'h0, 8'h84, 8'h00, 1'h0, 1'h1, 8'h00}, '{1'h0, 8'h20, 8'h00, 1'h0, 1'h0, 8'h00},
    '{1'h1, 8'h08, 8'h77, 1'h1, 1'h0, 8'h00}, '{1'h0, 8'h08, 8'h00, 1'h1, 1'h1, 8'h77}};

  always #10 clk = ~clk;

  crf_core_regs u_crf_core_regs (
    .clk(clk), .rst_b(rst_b), .dir_req(dir_req), .dir_rdata(dir_rdata), .dir_hit(dir_hit),
    .ind_req(ind_req), .ind_rdata(ind_rdata), .ind_hit(ind_hit), .bit_req(bit_req),
    .bit_rdata(bit_rdata), .bit_hit(bit_hit), .alu_upd(alu_upd), .rn_sel(rn_sel),
    .rn_we(rn_we), .rn_wdata(rn_wdata), .rn_rdata(rn_rdata), .pc_load(pc_load),
    .pc_value(pc_value), .pc_inc(pc_inc), .pc(pc), .sp_push(sp_push), .sp_pop(sp_pop),
    .stack_addr(stack_addr), .data_pointer_use(data_pointer_use), .data_pointer(data_pointer), .acc(acc), .b_reg(b_reg),
    .muldiv_pair(muldiv_pair), .status_word_flags(status_word_flags)
  );

  // ==========================================================================
  // helpers
  task automatic print_verdict();
    if (failures == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] time %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic clr();
    dir_req = '0;
    ind_req = '0;
    bit_req = '0;
    alu_upd = '0;
    rn_sel = 3'h0;
    rn_we = 1'h0;
    rn_wdata = 8'h00;
    pc_load = 1'h0;
    pc_value = 16'h0000;
    pc_inc = 1'h0;
    sp_push = 1'h0;
    sp_pop = 1'h0;
    data_pointer_use = 1'h0;
  endtask

  task automatic nxt();
    @(posedge clk);
    #1;
  endtask

  // one request edge, then back to idle; callers set requests after nxt()
  task automatic fire();
    nxt();
    clr();
  endtask

  task automatic dacc(input logic wr, input logic [7:0] a, input logic [7:0] d);
    nxt();
    dir_req = '{valid: 1'h1, write: wr, addr: a, wdata: d};
    fire();
  endtask

  // a hang counts as a mismatch and ends through the same verdict
  initial begin
    repeat (3000) @(posedge clk);
    failures++;
    print_verdict();
  end

  // ==========================================================================
  // main sequence
  initial begin
    clr();
    repeat (10) @(posedge clk);
    #1;
    rst_b = 1'h1;
    repeat (3) nxt();
    chk(pc, 16'h0000);
    chk(16'(stack_addr), 16'h0007);
    chk(16'(status_word_flags), 16'h0000);
    foreach (rows[i]) begin
      dacc(rows[i].wr, rows[i].addr, rows[i].wdata);
      chk(16'(dir_hit), 16'(rows[i].hit));
      if (rows[i].rd) chk(16'(dir_rdata), 16'(rows[i].rdata));
    end
    chk(data_pointer, 16'h1234);
    chk(muldiv_pair, 16'h5A96);
    rn_sel = 3'h0;
    #1 chk(16'(rn_rdata), 16'h0077);
    // indirect view: banks only, never the special registers
    nxt();
    ind_req = '{valid: 1'h1, write: 1'h0, addr: 8'hE0, wdata: 8'h00};
    fire();
    chk(16'(ind_hit), 16'h0000);
    nxt();
    ind_req = '{valid: 1'h1, write: 1'h0, addr: 8'h08, wdata: 8'h00};
    fire();
    chk(16'({ind_hit, ind_rdata}), 16'h0177);
    // indirect write in the same cycle as a direct bank access is dropped
    nxt();
    dir_req = '{valid: 1'h1, write: 1'h0, addr: 8'h08, wdata: 8'h00};
    ind_req = '{valid: 1'h1, write: 1'h1, addr: 8'h09, wdata: 8'h3C};
    fire();
    chk(16'({dir_hit, ind_hit, dir_rdata}), 16'h0277);
    for (int b = 0; b < 4; b++) begin
      dacc(1'h1, 8'hD0, 8'(b * 8));
      nxt();
      rn_sel = 3'(b + 1);
      rn_we = 1'h1;
      rn_wdata = 8'(8'hC0 + b);
      nxt();
      rn_we = 1'h0;
      chk(16'(rn_rdata), 16'(8'hC0 + b));
      dacc(1'h0, 8'(b * 9 + 1), 8'h00);
      chk(16'(dir_rdata), 16'(8'hC0 + b));
    end
    // parity and operand pair
    dacc(1'h1, 8'hD0, 8'h00);
    nxt();
    alu_upd.acc_we = 1'h1;
    alu_upd.acc = 8'h07;
    fire();
    chk(16'(status_word_flags), 16'h0001);
    nxt();
    alu_upd.acc_we = 1'h1;
    alu_upd.acc = 8'h03;
    alu_upd.b_we = 1'h1;
    alu_upd.b = 8'h21;
    fire();
    chk(16'(status_word_flags), 16'h0000);
    chk(muldiv_pair, 16'h2103);
    chk({b_reg, acc}, 16'h2103);
    // flag updates, clear-wrap, user flag by bit access only
    nxt();
    {alu_upd.cy_we, alu_upd.cy, alu_upd.ac_we, alu_upd.ac} = 4'hF;
    {alu_upd.ov_we, alu_upd.ov} = 2'h3;
    fire();
    chk(16'(status_word_flags), 16'h00C4);
    nxt();
    alu_upd.clr_ov = 1'h1;
    fire();
    chk(16'(status_word_flags), 16'h00C0);
    nxt();
    bit_req = '{valid: 1'h1, write: 1'h1, addr: 8'hD5, value: 1'h1};
    fire();
    chk(16'({bit_hit, status_word_flags}), 16'h01E0);
    nxt();
    bit_req = '{valid: 1'h1, write: 1'h0, addr: 8'hD5, value: 1'h0};
    fire();
    chk(16'({bit_hit, bit_rdata}), 16'h0003);
    nxt();
    {alu_upd.cy_we, alu_upd.cy, alu_upd.ac_we, alu_upd.ac} = 4'hA;
    {alu_upd.ov_we, alu_upd.ov} = 2'h2;
    fire();
    chk(16'(status_word_flags), 16'h0020);
    nxt();
    bit_req = '{valid: 1'h1, write: 1'h1, addr: 8'h85, value: 1'h1};
    fire();
    chk(16'(bit_hit), 16'h0000);
    // stack: step up before push, down after pop
    nxt();
    sp_push = 1'h1;
    #1 chk(16'(stack_addr), 16'h0008);
    nxt();
    #1 chk(16'(stack_addr), 16'h0009);
    nxt();
    {sp_push, sp_pop} = 2'h1;
    #1 chk(16'(stack_addr), 16'h0009);
    fire();
    chk(16'(stack_addr), 16'h0008);
    // instruction pointer: load beats step
    nxt();
    pc_inc = 1'h1;
    fire();
    chk(pc, 16'h0001);
    nxt();
    {pc_inc, pc_load, pc_value} = {2'h3, 16'hBEEF};
    fire();
    chk(pc, 16'hBEEF);
    // second pointer and auto step
    dacc(1'h1, 8'h86, 8'h01);
    nxt();
    data_pointer_use = 1'h1;
    fire();
    chk(data_pointer, 16'h1235);
    dacc(1'h1, 8'h85, 8'h01);
    chk(data_pointer, 16'h0000);
    dacc(1'h1, 8'h85, 8'h00);
    chk(data_pointer, 16'h1235);
    // auto toggle: each use steps the active pointer, then swaps to the other
    dacc(1'h1, 8'h86, 8'h09);
    dacc(1'h1, 8'h85, 8'h41);
    nxt();
    data_pointer_use = 1'h1;
    fire();
    chk(data_pointer, 16'h1235);
    nxt();
    data_pointer_use = 1'h1;
    fire();
    chk(data_pointer, 16'hFFFF);
    // reset in mid-run takes effect at once
    rst_b = 1'h0;
    #2 chk({pc[7:0], stack_addr}, 16'h0007);
    chk(16'(status_word_flags), 16'h0000);
    nxt();
    rst_b = 1'h1;
    repeat (3) nxt();
    chk(data_pointer, 16'h0000);
    print_verdict();
  end

endmodule

`default_nettype wire
